// ===== logic/uabd_pkg.sv
// Shared constants and types for the auto-baud measurement pair
package uabd_pkg;
    // Sync character the far end sends for calibration
    localparam logic [7:0] SYNC_CHAR = 8'h55;
    // Rising edges of the receive line that end a measurement
    localparam logic [2:0] LAST_EDGE = 3'h5;
    // Prescale divisors of the counter clock during measurement
    localparam int DIV_SLOW = 512;
    localparam int DIV_MID = 128;
    localparam int DIV_FAST = 32;
    localparam int PRE_W = 9;
    // High byte value that proves no carry in 8-bit modes
    localparam logic [7:0] NO_CARRY_HIGH = 8'h00;
    // Clock period of core_clk in ns
    localparam int CLK_PERIOD_NS = 40;
    // Width of the generator counter
    localparam int GEN_W = 16;
    // Measurement state
    typedef enum logic [1:0] {
        ABD_IDLE,
        ABD_WAIT_START,
        ABD_WAIT_RISE,
        ABD_COUNT
    } uabd_state_t;
endpackage : uabd_pkg

// ===== logic/uabd_link_if.sv
// Serial line between the remote transmitter and the measuring receiver
interface uabd_link_if;
    logic rx_line; // Idle high serial line
    modport device (input rx_line);
    modport remote (output rx_line);
endinterface : uabd_link_if

// ===== logic/uabd_remote_tx.sv
// Remote transmitter that sends the 8N1 sync character on request
module uabd_remote_tx
    import uabd_pkg::*;
(
    input wire logic core_clk,
    input wire logic srst,
    uabd_link_if.remote link,
    input wire logic send_req,
    input wire logic [15:0] bit_cycles,
    output logic busy
);
    ////////////////////////////////////////////////////////////////////
    logic [15:0] cnt_q;
    logic [3:0] idx_q;
    logic [9:0] frame_q;
    logic act_q;
    logic line_q;

    // Frame shifter: start bit, 55h lsb first, stop bit
    always_ff @(posedge core_clk) begin
        if (srst) begin
            act_q <= 1'b0;
            cnt_q <= 16'h0000;
            idx_q <= 4'h0;
            frame_q <= 10'h3ff;
            line_q <= 1'b1;
        end else if (!act_q) begin
            line_q <= 1'b1;
            if (send_req) begin
                act_q <= 1'b1;
                frame_q <= {1'b1, SYNC_CHAR, 1'b0};
                idx_q <= 4'h0;
                cnt_q <= 16'h0000;
                line_q <= 1'b0;
            end
        end else if (cnt_q + 16'h0001 >= bit_cycles) begin
            cnt_q <= 16'h0000;
            if (idx_q == 4'h9) begin
                act_q <= 1'b0;
                line_q <= 1'b1;
            end else begin
                idx_q <= idx_q + 4'h1;
                line_q <= frame_q[idx_q + 4'h1];
            end
        end else begin
            cnt_q <= cnt_q + 16'h0001;
        end
    end
    // Caller keeps the rate in measurable range
    assign link.rx_line = line_q;
    assign busy = act_q;
endmodule : uabd_remote_tx

// ===== logic/uabd_measure.sv
// Auto-baud measurement of the receive line using the generator counter
module uabd_measure
    import uabd_pkg::*;
(
    input wire logic core_clk,
    input wire logic srst,
    uabd_link_if.device link,
    input wire logic sync_mode,
    input wire logic wake_on_break_enable,
    input wire logic wide_divisor_select,
    input wire logic high_speed_select,
    input wire logic auto_baud_set,
    input wire logic receive_data_read,
    output logic auto_baud_enable,
    output logic auto_baud_measure,
    output logic [7:0] baud_divisor_low,
    output logic [7:0] baud_divisor_high,
    output logic receive_complete_flag,
    output logic receiver_idle_flag,
    output logic baud_generator_tick
);
    ////////////////////////////////////////////////////////////////////
    logic rx_meta_q; // First synchroniser stage, read only by the next
    logic rx_sync_q; // Second stage
    logic rx_prev_q; // Edge detector history
    logic rise; // Rising edge of the synchronised line
    logic fall; // Falling edge, start bit
    logic [PRE_W-1:0] pre_q; // Prescaler for the counter clock
    logic [PRE_W-1:0] pre_top; // Terminal count of prescaler
    logic tick; // One counter clock
    logic [GEN_W-1:0] gen_q; // Combined divisor counter
    logic [2:0] edge_q; // Rising edges seen so far
    logic [1:0] brk_q; // Break skip progress under wake-on-break
    logic en_q; // Enable bit, software set, hardware clear
    logic rcf_q; // Sticky receive complete flag
    logic ok_mode; // Port is in asynchronous mode
    logic last_rise; // Fifth rising edge while counting
    uabd_state_t st_q; // Measurement sequencer state

    ////////////////////////////////////////////////////////////////////
    // Two-flop synchroniser, pin is asynchronous
    // Reset to idle high so no false edge follows reset
    always_ff @(posedge core_clk) begin
        if (srst) begin
            rx_meta_q <= 1'b1;
            rx_sync_q <= 1'b1;
            rx_prev_q <= 1'b1;
        end else begin
            rx_meta_q <= link.rx_line;
            rx_sync_q <= rx_meta_q;
            rx_prev_q <= rx_sync_q;
        end
    end
    // Edges come from the second stage and its history, so a metastable
    // first stage can at most shift an edge by one cycle
    assign rise = rx_sync_q & ~rx_prev_q;
    assign fall = ~rx_sync_q & rx_prev_q;

    // Async mode needs the synchronous bit clear
    // Wake-on-break is handled in the sequencer, not here
    assign ok_mode = ~sync_mode;

    ////////////////////////////////////////////////////////////////////
    // Counter clock: the normal 4x/16x/64x base divided by eight
    always_comb begin
        unique case ({wide_divisor_select, high_speed_select})
            2'b00: pre_top = PRE_W'(DIV_SLOW - 1);
            2'b11: pre_top = PRE_W'(DIV_FAST - 1);
            default: pre_top = PRE_W'(DIV_MID - 1);
        endcase
    end

    // Free-running prescaler restarted at the first rising edge
    // Held at zero outside counting so the first tick is a full period
    always_ff @(posedge core_clk) begin
        if (srst) begin
            pre_q <= '0;
        end else if (st_q != ABD_COUNT || pre_q == pre_top) begin
            pre_q <= '0;
        end else begin
            pre_q <= pre_q + PRE_W'(1);
        end
    end
    assign tick = (st_q == ABD_COUNT) && (pre_q == pre_top);
    // The tick runs only while counting; outside measurement it stays low
    assign baud_generator_tick = tick;

    ////////////////////////////////////////////////////////////////////
    // Fifth rising edge ends the count; edge one was taken on entry
    assign last_rise = (st_q == ABD_COUNT) && rise
        && (edge_q == LAST_EDGE - 3'h1);

    // Sequencer: clear, wait start, wait first rise, count
    // Arming is honoured in every state, so a sync character that was
    // missed or cut can simply be retried by software
    always_ff @(posedge core_clk) begin
        if (srst) begin
            st_q <= ABD_IDLE;
            edge_q <= 3'h0;
            brk_q <= 2'h0;
        end else if (auto_baud_set && ok_mode) begin
            st_q <= ABD_WAIT_START;
            edge_q <= 3'h0;
            // Break character must pass first
            brk_q <= wake_on_break_enable ? 2'h1 : 2'h0;
        end else if (!ok_mode) begin
            // Synchronous mode abandons any measurement
            st_q <= ABD_IDLE;
        end else begin
            unique case (st_q)
                ABD_IDLE: begin
                    // Nothing to do until software arms
                end
                ABD_WAIT_START: begin
                    if (brk_q == 2'h1 && fall) begin
                        brk_q <= 2'h2; // Break low begins
                    end else if (brk_q == 2'h2 && rise) begin
                        brk_q <= 2'h0; // Break ended
                    end else if (brk_q == 2'h0 && fall) begin
                        st_q <= ABD_WAIT_RISE;
                    end
                end
                ABD_WAIT_RISE: begin
                    // Start bit seen; counting opens on bit zero
                    if (rise) begin
                        st_q <= ABD_COUNT;
                        edge_q <= 3'h1;
                    end
                end
                ABD_COUNT: begin
                    if (rise) begin
                        edge_q <= edge_q + 3'h1;
                        if (last_rise) begin
                            st_q <= ABD_IDLE;
                        end
                    end
                end
            endcase
        end
    end

    // Enable bit: set by software, cleared on the fifth edge
    // Arm wins over the fifth edge, matching the sequencer restart
    always_ff @(posedge core_clk) begin
        if (srst) begin
            en_q <= 1'b0;
        end else if (auto_baud_set && ok_mode) begin
            en_q <= 1'b1;
        end else if (last_rise || !ok_mode) begin
            en_q <= 1'b0;
        end
    end

    // 16-bit counter over both bytes, whatever the width bit
    // The tick of the fifth edge is dropped so the count stops there
    always_ff @(posedge core_clk) begin
        if (srst) begin
            gen_q <= '0;
        end else if (auto_baud_set && ok_mode) begin
            gen_q <= '0;
        end else if (tick && !last_rise) begin
            gen_q <= gen_q + GEN_W'(1);
        end
    end

    // Receive complete flag: set wins over the read that clears it
    always_ff @(posedge core_clk) begin
        if (srst) begin
            rcf_q <= 1'b0;
        end else if (last_rise) begin
            rcf_q <= 1'b1;
        end else if (receive_data_read) begin
            rcf_q <= 1'b0;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // Limitation: the count wraps past 16 bits; a rate too slow for the
    // chosen prescale reads back as a small, wrong value
    // High byte reads NO_CARRY_HIGH when 8-bit mode fit
    assign baud_divisor_low = gen_q[7:0];
    assign baud_divisor_high = gen_q[15:8];
    assign auto_baud_enable = en_q;
    assign auto_baud_measure = (st_q != ABD_IDLE);
    assign receive_complete_flag = rcf_q;
    // Receiver idle flag held low while measuring
    assign receiver_idle_flag = (st_q == ABD_IDLE) ? rx_sync_q : 1'b0;
endmodule : uabd_measure

// ===== dv/uabd_asserts.sv
// Concurrent checks on the auto-baud measurement pair
module uabd_asserts
(
    input wire logic core_clk,
    input wire logic srst,
    input wire logic rx_line,
    input wire logic sync_mode,
    input wire logic auto_baud_set,
    input wire logic receive_data_read,
    input wire logic auto_baud_enable,
    input wire logic auto_baud_measure,
    input wire logic [7:0] baud_divisor_low,
    input wire logic [7:0] baud_divisor_high,
    input wire logic receive_complete_flag,
    input wire logic receiver_idle_flag
);
    timeunit 1ns;
    timeprecision 1ns;
    // Both bytes seen as one counter
    logic [15:0] cnt;
    assign cnt = {baud_divisor_high, baud_divisor_low};
    default clocking @(posedge core_clk); endclocking
    default disable iff (srst);
    ////////////////////////////////////////////////////////////////////
    a_arm_sets_enable: assert property (auto_baud_set && !sync_mode |=>
        auto_baud_enable) else $error("arm did not set enable");
    a_arm_clears_count: assert property (
        auto_baud_set && !sync_mode |=> cnt == 16'h0000)
        else $error("arm did not clear counter");
    a_sync_refuses_arm: assert property (
        sync_mode && auto_baud_set && !auto_baud_enable |=> !auto_baud_enable)
        else $error("arm taken in synchronous mode");
    a_done_sets_flag: assert property (
        $fell(auto_baud_enable) && !$past(sync_mode) |-> receive_complete_flag)
        else $error("enable dropped without flag");
    a_count_frozen: assert property (
        !auto_baud_enable && !auto_baud_set |=> $stable(cnt))
        else $error("counter moved while disarmed");
    a_count_steps_one: assert property ($changed(cnt) &&
        $past(auto_baud_enable) && !$past(auto_baud_set)
        |-> cnt == $past(cnt) + 16'h0001) else $error("counter step wrong");
    // Fastest prescale is 32 cycles, so eight quiet cycles must follow
    a_tick_gap: assert property (
        $changed(cnt) && !$past(auto_baud_set) |=> $stable(cnt)[*8])
        else $error("counter ticks too fast");
    a_idle_held: assert property (auto_baud_measure |->
        !receiver_idle_flag) else $error("receiver idle while measuring");
    // Outside measurement the idle flag is the line two clocks late
    a_idle_follows_line: assert property (
        !auto_baud_measure |-> receiver_idle_flag == $past(rx_line, 2))
        else $error("idle flag does not follow the line");
    a_read_clears: assert property (
        receive_data_read && !auto_baud_enable |=> !receive_complete_flag)
        else $error("read did not clear flag");
    ////////////////////////////////////////////////////////////////////
    c_done: cover property ($fell(auto_baud_enable) && receive_complete_flag);
    c_refused: cover property (auto_baud_set && sync_mode);
    c_carry: cover property ($changed(baud_divisor_high));
endmodule : uabd_asserts

// ===== dv/test_uart_auto_baud_detect.sv
// Self-checking bench joining the remote sender and the measuring end
module test_uart_auto_baud_detect;
    timeunit 1ns;
    timeprecision 1ns;
    import uabd_pkg::*;
    // One table row: selects, bit length and the count it must give
    typedef struct {
        logic w;
        logic h;
        logic [15:0] bc;
        logic [15:0] ex;
    } uabd_row_t;
    // Bit lengths leave half a prescale of margin around the expected count
    // and stay inside what each prescale can measure
    uabd_row_t rows [4] = '{'{1'b0, 1'b0, 16'h0160, 16'h0005},
        '{1'b0, 1'b1, 16'h0058, 16'h0005}, '{1'b1, 1'b0, 16'h0258, 16'h0025},
        '{1'b1, 1'b1, 16'h0802, 16'h0200}};
    logic core_clk = 1'b0, srst = 1'b1, sync_mode = 1'b0;
    logic wake_on_break_enable = 1'b0, wide_divisor_select = 1'b0;
    logic high_speed_select = 1'b0, auto_baud_set = 1'b0;
    logic receive_data_read = 1'b0, send_req = 1'b0, busy;
    logic [15:0] bit_cycles = 16'h0058;
    logic auto_baud_enable, auto_baud_measure, receive_complete_flag;
    logic receiver_idle_flag;
    logic [7:0] baud_divisor_low, baud_divisor_high;
    logic gen_tick; // Counter clock strobe from the measuring end
    logic [15:0] div; // Both divisor bytes as one word
    logic [15:0] hi_word; // High byte widened for comparison
    logic [15:0] ticks = 16'h0000; // Counter ticks since the last arm
    // High byte that proves no carry, widened for comparison
    localparam logic [15:0] NO_CARRY_WORD = {8'h00, NO_CARRY_HIGH};
    assign div = {baud_divisor_high, baud_divisor_low};
    assign hi_word = {8'h00, baud_divisor_high};
    // Count every strobe since the last arm; unlike the counter, the tick of the fifth edge is kept
    always @(posedge core_clk) begin
        if (auto_baud_set === 1'b1) ticks <= 16'h0000;
        else if (gen_tick === 1'b1) ticks <= ticks + 16'h0001;
    end
    int err_total = 0, total_checks = 0;
    uabd_link_if link_i ();
    ////////////////////////////////////////////////////////////////////
    // Both ends face each other across the link
    uabd_remote_tx uabd_remote_tx_i (.core_clk, .srst, .link(link_i),
        .send_req, .bit_cycles, .busy);
    uabd_measure uabd_measure_i (.core_clk, .srst, .link(link_i), .sync_mode,
        .wake_on_break_enable, .wide_divisor_select, .high_speed_select,
        .auto_baud_set, .receive_data_read, .auto_baud_enable,
        .auto_baud_measure, .baud_divisor_low, .baud_divisor_high,
        .receive_complete_flag, .receiver_idle_flag,
        .baud_generator_tick(gen_tick));
    uabd_asserts uabd_asserts_i (.core_clk, .srst, .rx_line(link_i.rx_line),
        .sync_mode, .auto_baud_set, .receive_data_read, .auto_baud_enable,
        .auto_baud_measure, .baud_divisor_low, .baud_divisor_high,
        .receive_complete_flag, .receiver_idle_flag);
    // Half-period toggle gives 40 ns
    always #(CLK_PERIOD_NS / 2) core_clk = ~core_clk;
    ////////////////////////////////////////////////////////////////////
    // Verdict in one place
    task automatic end_of_test();
        $display("checks %0d errors %0d", total_checks, err_total);
        if (err_total == 0 && total_checks > 0) $display("Regression OK");
        else $display("Regression broken");
        $finish;
    endtask : end_of_test
    // Compare and count
    task automatic check(string nm, logic [15:0] seen, logic [15:0] ex);
        total_checks++;
        if (seen !== ex) begin
            err_total++;
            $display("ERROR %s expected %h seen %h", nm, ex, seen);
        end
    endtask : check
    // One-cycle pulse on a strobe
    task automatic arm();
        @(posedge core_clk) auto_baud_set <= 1'b1;
        @(posedge core_clk) auto_baud_set <= 1'b0;
    endtask : arm
    // Send one sync character and wait until the line is idle again
    task automatic send();
        int n;
        n = 0;
        @(posedge core_clk) send_req <= 1'b1;
        @(posedge core_clk) send_req <= 1'b0;
        repeat (2) @(posedge core_clk);
        while (busy === 1'b1 && n < 30000) begin
            @(posedge core_clk);
            n++;
        end
        #1;
    endtask : send
    ////////////////////////////////////////////////////////////////////
    // Hang guard, well beyond the expected run
    initial begin
        repeat (80000) @(posedge core_clk);
        err_total++;
        end_of_test();
    end
    // Main sequence
    initial begin
        repeat (6) @(posedge core_clk);
        srst <= 1'b0;
        foreach (rows[i]) begin
            @(posedge core_clk);
            wide_divisor_select <= rows[i].w;
            high_speed_select <= rows[i].h;
            bit_cycles <= rows[i].bc;
            arm();
            @(posedge core_clk) #1;
            check("armed", auto_baud_enable, 16'h1);
            check("cleared", div, 16'h0000);
            check("idle", receiver_idle_flag, 16'h0);
            send();
            check("enable", auto_baud_enable, 16'h0);
            check("flag", receive_complete_flag, 16'h1);
            check("count", div, rows[i].ex);
            check("ticks", ticks, rows[i].ex);
            // Without the wide select only the low byte may be used
            if (!rows[i].w) begin
                check("high", hi_word, NO_CARRY_WORD);
            end
            @(posedge core_clk) receive_data_read <= 1'b1;
            @(posedge core_clk) receive_data_read <= 1'b0;
            @(posedge core_clk) #1;
            check("cleared flag", receive_complete_flag, 16'h0);
        end
        @(posedge core_clk);
        sync_mode <= 1'b1;
        arm();
        @(posedge core_clk) #1;
        check("sync arm", auto_baud_enable, 16'h0);
        @(posedge core_clk);
        sync_mode <= 1'b0;
        wake_on_break_enable <= 1'b1;
        bit_cycles <= 16'h0058;
        arm();
        send();
        check("after break", auto_baud_enable, 16'h1);
        check("wake measure", auto_baud_measure, 16'h1);
        @(posedge core_clk);
        srst <= 1'b1;
        repeat (3) @(posedge core_clk);
        srst <= 1'b0;
        @(posedge core_clk) #1;
        check("reset enable", auto_baud_enable, 16'h0);
        check("reset count", div, 16'h0000);
        end_of_test();
    end
endmodule : test_uart_auto_baud_detect
